// file: hdl/adc_ctrl_pkg.sv
// Package of register map, field positions and timing for the converter control
package adc_ctrl_pkg;
  localparam logic [3:0] OFS_CONTROL    = 4'h0;
  localparam logic [3:0] OFS_CONFIG     = 4'h4;
  localparam logic [3:0] OFS_CHANNEL    = 4'h8;
  localparam logic [3:0] OFS_PAIR       = 4'hc;
  localparam logic [3:0] OFS_RES_HIGH   = 4'h1;
  localparam int unsigned BIT_ENABLE    = 7;
  localparam int unsigned BIT_TRACK     = 6;
  localparam int unsigned BIT_DONE      = 5;
  localparam int unsigned BIT_BUSY      = 4;
  localparam int unsigned BIT_MODE_HI   = 3;
  localparam int unsigned BIT_MODE_LO   = 2;
  localparam int unsigned BIT_LJUST     = 0;
  localparam logic [7:0] RST_CONTROL    = 8'h00;
  localparam logic [7:0] RST_CONFIG     = 8'hf8;
  localparam logic [7:0] RST_CHANNEL    = 8'h00;
  localparam logic [7:0] RST_PAIR       = 8'h00;
  localparam logic [3:0] PAIR_MASK      = 4'hf;
  localparam logic [2:0] GAIN_UNITY     = 3'h0;
  localparam int unsigned TRACK_CLOCKS  = 3;
  localparam int unsigned SAR_CLOCKS    = 16;
  localparam int unsigned SYS_HZ        = 25000000;
  localparam int unsigned MAX_SPS       = 100000;
  localparam int unsigned MIN_CONV_CYC  = (SYS_HZ + MAX_SPS - 1) / MAX_SPS;
  localparam int unsigned RES_BITS      = 10;
  localparam int unsigned TEMP_CHANNEL  = 8;
  typedef enum logic [1:0] {
    START_SOFT = 2'h0, START_TMR3 = 2'h1, START_EXT = 2'h2, START_TMR2 = 2'h3
  } start_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1, ST_TRACK = 4'h2, ST_CONV = 4'h4, ST_HOLD = 4'h8
  } conv_state_t;
  typedef struct packed {
    logic       enable;
    logic       track_mode;
    logic       left_justify;
    logic [1:0] start_mode;
  } ctrl_bits_t;
endpackage

// file: hdl/sar_div.sv
// Conversion clock enable divider
`timescale 1ns/1ps
module sar_div
  import adc_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [4:0] divider,
  output logic            tick
);
  logic [5:0] cnt_q;
  logic [5:0] half;
  // Period is 2*(divider+1) system clocks
  assign half = {divider, 1'b1};
  always_ff @(posedge clk)
  begin
    if (rst || !run)
    begin
      cnt_q <= 6'h00;
      tick  <= 1'b0;
    end
    else if (cnt_q >= half)
    begin
      cnt_q <= 6'h00;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 6'h01;
      tick  <= 1'b0;
    end
  end
endmodule // sar_div

// file: hdl/sar_adc_conversion_control.sv
// Converter control with Avalon-MM register slave
// Summary of operation
// - Enable bit gates everything; else shutdown. Mux, pair and gain outputs still follow their registers while disabled.
// - Nine channels, ninth is temperature sensor.
// - Pairs single-ended or differential, changeable anytime.
// - Reset leaves all pairs single-ended.
// - Three-bit gain field, unity after reset.
// - Temperature channel routed through gain stage.
// - Conversion clock divides system clock.
// - Conversion rate never above 100 ksps.
// - Two-bit field picks one start source.
// - Busy reads one during whole conversion.
// - Conversion end clears busy and sets done flag.
// - Result justified left or right.
// - Default mode tracks continuously when idle.
// - Low-power mode tracks three conversion clocks.
// - External low-power: track low, convert rising.
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module sar_adc_conversion_control
  import adc_ctrl_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        TIMER3_OVF,
  input  wire logic        TIMER2_OVF,
  input  wire logic        EXT_START,
  input  wire logic        SAR_BIT,
  output logic             ANALOG_POWER,
  output logic             TRACK_EN,
  output logic             SAR_STEP,
  output logic [3:0]       MUX_SELECT,
  output logic [3:0]       PAIR_DIFF,
  output logic             MUX_DIFF,
  output logic [2:0]       GAIN_SELECT
);
  ctrl_bits_t  ctl_q;
  logic        done_q;
  logic        busy_q;
  logic [7:0]  cfg_q;
  logic [3:0]  chan_q;
  logic [3:0]  pair_q;
  logic [RES_BITS-1:0] res_q;
  logic [RES_BITS-1:0] sh_q;
  logic        diff_q;
  logic        take_q;
  logic        res_diff_q;
  logic        ext_q;
  logic [4:0]  cnt_q;
  logic [9:0]  rate_q;
  conv_state_t st_q;
  logic        tick;
  logic        ack_q;
  logic        wr;
  logic        rd;
  logic        start;
  logic        soft_start;
  logic        ext_rise;
  logic        sel_diff;
  logic [15:0] word;
  logic        finish;

  assign wr = AVS_WRITE && !ack_q;
  assign rd = AVS_READ && !ack_q;
  assign soft_start = wr && AVS_ADDRESS == OFS_CONTROL && AVS_BYTEENABLE[0]
                      && AVS_WRITEDATA[BIT_BUSY];
  assign ext_rise = EXT_START && !ext_q;
  // Selected channel differential when its pair bit is set
  assign sel_diff = !chan_q[3] && pair_q[chan_q[2:1]];

  always_comb
  begin
    unique case (start_mode_t'(ctl_q.start_mode))
      START_SOFT: start = soft_start;
      START_TMR3: start = TIMER3_OVF;
      START_EXT:  start = ext_rise;
      START_TMR2: start = TIMER2_OVF;
    endcase
  end

  sar_div u_div
  (
    .clk     (CLK_SYS),
    .rst     (SYS_RST),
    .run     (ctl_q.enable && st_q != ST_IDLE),
    .divider (cfg_q[7:3]),
    .tick    (tick)
  );

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      ext_q <= 1'b0;
    else
      ext_q <= EXT_START;
  end

  // Rate guard: a new start is ignored until the minimum period passed
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      rate_q <= 10'h000;
    else if (st_q == ST_IDLE && start && rate_q == 10'h000 && ctl_q.enable)
      rate_q <= 10'((MIN_CONV_CYC) - 1);
    else if (rate_q != 10'h000)
      rate_q <= rate_q - 10'h001;
  end

  assign finish = st_q == ST_CONV && tick && cnt_q == 5'(SAR_CLOCKS - 1);

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST || !ctl_q.enable)
    begin
      st_q   <= ST_IDLE;
      busy_q <= 1'b0;
      cnt_q  <= 5'h00;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
          if (start && rate_q == 10'h000)
          begin
            busy_q <= 1'b1;
            cnt_q  <= 5'h00;
            if (ctl_q.track_mode && ctl_q.start_mode == START_EXT)
              st_q <= ST_CONV;
            else if (ctl_q.track_mode)
              st_q <= ST_TRACK;
            else
              st_q <= ST_CONV;
          end
        ST_TRACK:
          if (tick)
          begin
            if (cnt_q == 5'(TRACK_CLOCKS - 1))
            begin
              cnt_q <= 5'h00;
              st_q  <= ST_CONV;
            end
            else
              cnt_q <= cnt_q + 5'h01;
          end
        ST_CONV:
          if (tick)
          begin
            if (finish)
            begin
              busy_q <= 1'b0;
              st_q   <= ST_HOLD;
            end
            cnt_q <= cnt_q + 5'h01;
          end
        ST_HOLD:
          st_q <= ST_IDLE;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // Successive bits from the comparator, MSB first
  // Decision is valid while SAR_STEP stands, one cycle after tick
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      take_q     <= 1'b0;
      sh_q       <= '0;
      res_q      <= '0;
      diff_q     <= 1'b0;
      res_diff_q <= 1'b0;
    end
    else
    begin
      take_q <= st_q == ST_CONV && tick && cnt_q < 5'(RES_BITS);
      if (take_q)
        sh_q <= {sh_q[RES_BITS-2:0], SAR_BIT};
      if (st_q == ST_IDLE && start)
        diff_q <= sel_diff;
      if (st_q == ST_HOLD)
      begin
        // Comparator works offset binary; differential flips MSB
        res_q      <= {sh_q[RES_BITS-1] ^ diff_q, sh_q[RES_BITS-2:0]};
        res_diff_q <= diff_q;
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      ctl_q  <= ctrl_bits_t'(5'h00);
      cfg_q  <= RST_CONFIG;
      chan_q <= RST_CHANNEL[3:0];
      pair_q <= RST_PAIR[3:0];
    end
    else if (wr && AVS_BYTEENABLE[0])
    begin
      unique case (AVS_ADDRESS)
        OFS_CONTROL:
        begin
          ctl_q.enable       <= AVS_WRITEDATA[BIT_ENABLE];
          ctl_q.track_mode   <= AVS_WRITEDATA[BIT_TRACK];
          ctl_q.start_mode   <= AVS_WRITEDATA[BIT_MODE_HI:BIT_MODE_LO];
          ctl_q.left_justify <= AVS_WRITEDATA[BIT_LJUST];
        end
        OFS_CONFIG:  cfg_q  <= AVS_WRITEDATA[7:0];
        OFS_CHANNEL: chan_q <= AVS_WRITEDATA[3:0];
        OFS_PAIR:    pair_q <= AVS_WRITEDATA[3:0] & PAIR_MASK;
        default:     ;
      endcase
    end
  end

  // Completion flag; hardware set wins over software clear
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      done_q <= 1'b0;
    else if (finish)
      done_q <= 1'b1;
    else if (wr && AVS_BYTEENABLE[0] && AVS_ADDRESS == OFS_CONTROL
             && !AVS_WRITEDATA[BIT_DONE])
      done_q <= 1'b0;
  end

  assign word = ctl_q.left_justify ? {res_q, 6'h00}
              : {{6{res_q[RES_BITS-1] & res_diff_q}}, res_q};

  // One wait state: answer registered at first edge, taken at second
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      ack_q           <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end
    else
    begin
      ack_q           <= (AVS_READ || AVS_WRITE) && !ack_q;
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_q);
      if (rd)
      begin
        unique case (AVS_ADDRESS)
          OFS_CONTROL:  AVS_READDATA <= {24'h0, ctl_q.enable, ctl_q.track_mode, done_q,
                                         busy_q, ctl_q.start_mode, 1'b0,
                                         ctl_q.left_justify};
          OFS_CONFIG:   AVS_READDATA <= {24'h0, cfg_q};
          OFS_CHANNEL:  AVS_READDATA <= {28'h0, chan_q};
          OFS_PAIR:     AVS_READDATA <= {28'h0, pair_q};
          OFS_RES_HIGH: AVS_READDATA <= {16'h0, word};
          default:      AVS_READDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      ANALOG_POWER <= 1'b0;
      TRACK_EN     <= 1'b0;
      SAR_STEP     <= 1'b0;
      MUX_SELECT   <= 4'h0;
      PAIR_DIFF    <= 4'h0;
      MUX_DIFF     <= 1'b0;
      GAIN_SELECT  <= GAIN_UNITY;
    end
    else
    begin
      ANALOG_POWER <= ctl_q.enable;
      // Ext low-power tracks only while the pin is low
      TRACK_EN     <= ctl_q.enable && (st_q == ST_TRACK ||
                      (st_q == ST_IDLE && (!ctl_q.track_mode ||
                      (ctl_q.start_mode == START_EXT && !EXT_START))));
      SAR_STEP     <= st_q == ST_CONV && tick;
      MUX_SELECT   <= chan_q[3] ? 4'(TEMP_CHANNEL) : chan_q;
      PAIR_DIFF    <= pair_q;
      MUX_DIFF     <= sel_diff;
      GAIN_SELECT  <= cfg_q[2:0];
    end
  end

  busy_flag_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $fell(busy_q) && $past(ctl_q.enable) |-> done_q) else $error("done not set");
  busy_state_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    busy_q |-> (st_q == ST_TRACK || st_q == ST_CONV)) else $error("busy mismatch");
  shutdown_idle_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !ctl_q.enable |=> st_q == ST_IDLE) else $error("active while disabled");
  pair_upper_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !AVS_WAITREQUEST && $past(AVS_ADDRESS) == OFS_PAIR && $past(AVS_READ)
    |-> AVS_READDATA[31:4] == 28'h0) else $error("pair upper bits");
  track_len_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $rose(st_q == ST_TRACK) |-> st_q == ST_TRACK [*3]) else $error("track short");
  rate_guard_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $rose(busy_q) |-> rate_q != 10'h000) else $error("rate guard idle");
  gain_drive_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    ##1 GAIN_SELECT == $past(cfg_q[2:0])) else $error("gain not driven");
  temp_route_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    $past(chan_q[3]) |-> MUX_SELECT == 4'h8) else $error("temp route");
  power_follow_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    ANALOG_POWER == $past(ctl_q.enable)) else $error("power state");
endmodule // sar_adc_conversion_control

// file: tb/afe_model.sv
// Behavioural comparator front end feeding decision bits
`timescale 1ns/1ps
module afe_model
(
  input  wire logic       clk,
  input  wire logic       track,
  input  wire logic       power,
  input  wire logic       step,
  input  wire logic [9:0] code,
  output logic            bit_out
);
  logic [3:0] idx_q;
  logic       tog_q = 1'b0;
  // Bits are only valid in step cycles; elsewhere the line wanders
  always_ff @(posedge clk)
  begin
    tog_q <= ~tog_q;
    if (track || !power)
      idx_q <= 4'h0;
    else if (step)
      idx_q <= idx_q + 4'h1;
  end
  assign bit_out = (step && idx_q < 4'ha) ? code[4'h9 - idx_q] : tog_q;
endmodule // afe_model

// file: tb/tb_sar_adc_conversion_control.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_sar_adc_conversion_control
  import adc_ctrl_pkg::*;
;
  logic        CLK_SYS = 1'b0;
  logic        SYS_RST = 1'b1;
  logic [3:0]  AVS_ADDRESS = 4'h0;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0]  AVS_BYTEENABLE = 4'h0;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic        TIMER3_OVF = 1'b0;
  logic        TIMER2_OVF = 1'b0;
  logic        EXT_START = 1'b0;
  logic        SAR_BIT;
  logic        ANALOG_POWER;
  logic        TRACK_EN;
  logic        SAR_STEP;
  logic [3:0]  MUX_SELECT;
  logic [3:0]  PAIR_DIFF;
  logic        MUX_DIFF;
  logic [2:0]  GAIN_SELECT;
  logic [9:0]  code = 10'h0;
  logic [31:0] seed = 32'h7cc412d1;
  logic [31:0] q;
  int          n_fail = 0;
  int          n_tests = 0;
  int          n_step = 0;
  int          since = 0;
  int          gap = 0;
  initial forever #20 CLK_SYS = ~CLK_SYS;
  // Count and spacing of conversion clocks as the front end sees them
  always @(posedge CLK_SYS)
  begin
    since <= SAR_STEP ? 1 : since + 1;
    if (SAR_STEP)
    begin
      n_step <= n_step + 1;
      gap    <= since;
    end
  end
  sar_adc_conversion_control i_dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .TIMER3_OVF(TIMER3_OVF), .TIMER2_OVF(TIMER2_OVF), .EXT_START(EXT_START),
    .SAR_BIT(SAR_BIT), .ANALOG_POWER(ANALOG_POWER), .TRACK_EN(TRACK_EN),
    .SAR_STEP(SAR_STEP), .MUX_SELECT(MUX_SELECT), .PAIR_DIFF(PAIR_DIFF),
    .MUX_DIFF(MUX_DIFF), .GAIN_SELECT(GAIN_SELECT));
  afe_model i_afe (.clk(CLK_SYS), .track(TRACK_EN), .power(ANALOG_POWER),
    .step(SAR_STEP), .code(code), .bit_out(SAR_BIT));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Differential codes arrive offset binary; bench flips the sign bit
  function automatic logic [15:0] exp_res(input logic [9:0] c, input logic d, input logic lj);
    logic [9:0] v;
    v = d ? (c ^ 10'h200) : c;
    if (lj)
      return {v, 6'h0};
    return d ? {{6{v[9]}}, v} : {6'h0, v};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= 4'hf;
    @(posedge CLK_SYS);
    while (AVS_WAITREQUEST !== 1'b0 && n < 50)
    begin
      @(posedge CLK_SYS);
      n++;
    end
    if (n >= 50)
      chk(32'h1, 32'h0);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic pulse(input int m);
    if (m == 1)
      TIMER3_OVF <= 1'b1;
    else
      TIMER2_OVF <= 1'b1;
    @(posedge CLK_SYS);
    TIMER3_OVF <= 1'b0;
    TIMER2_OVF <= 1'b0;
  endtask
  initial
  begin
    #(40 * 60000);
    chk(32'h1, 32'h0);
    summarize();
  end
  initial
  begin
    logic [7:0] ctl;
    logic       d;
    logic       lj;
    logic [1:0] dv;
    int         n;
    int         s0;
    repeat (8) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    @(posedge CLK_SYS);
    bus(1'b0, OFS_CONTROL, 32'h0);
    chk(q, {24'h0, RST_CONTROL});
    bus(1'b0, OFS_CONFIG, 32'h0);
    chk(q, {24'h0, RST_CONFIG});
    chk({29'h0, GAIN_SELECT}, {29'h0, GAIN_UNITY});
    bus(1'b0, OFS_PAIR, 32'h0);
    chk(q, {24'h0, RST_PAIR});
    chk({28'h0, PAIR_DIFF}, 32'h0);
    chk({31'h0, ANALOG_POWER}, 32'h0);
    bus(1'b0, 4'h3, 32'h0);
    chk(q, 32'h0);
    $display("reset test done");
    bus(1'b1, OFS_CHANNEL, 32'h8);
    chk({28'h0, MUX_SELECT}, 32'h8);
    bus(1'b1, OFS_CHANNEL, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      int m;
      m = k % 4;
      seed = lfsr(seed);
      code <= seed[9:0];
      d = seed[12];
      lj = seed[13];
      dv = seed[24:23];
      bus(1'b1, OFS_PAIR, {24'h0, seed[19:16], seed[29:27], d});
      chk({28'h0, PAIR_DIFF}, {28'h0, seed[29:27], d});
      chk({31'h0, MUX_DIFF}, {31'h0, d});
      bus(1'b0, OFS_PAIR, 32'h0);
      chk(q, {28'h0, seed[29:27], d});
      bus(1'b1, OFS_CONFIG, {24'h0, 3'h0, dv, seed[22:20]});
      chk({29'h0, GAIN_SELECT}, {29'h0, seed[22:20]});
      // Settling after mux and gain changes, at least 1.5 us
      repeat (38) @(posedge CLK_SYS);
      ctl = 8'h80 | (m >= 2 ? 8'h40 : 8'h0) | (m[1:0] << 2) | {7'h0, lj};
      bus(1'b1, OFS_CONTROL, {24'h0, ctl});
      chk({31'h0, ANALOG_POWER}, 32'h1);
      if (m == 2)
        chk({31'h0, TRACK_EN}, 32'h1);
      s0 = n_step;
      if (m == 0)
      begin
        bus(1'b1, OFS_CONTROL, {24'h0, ctl | 8'h10});
        bus(1'b0, OFS_CONTROL, 32'h0);
        chk(q[BIT_BUSY], 1'b1);
      end
      else if (m == 2)
        EXT_START <= 1'b1;
      else
        pulse(m);
      n = 0;
      q = 32'h0;
      while (q[BIT_DONE] !== 1'b1 && n < 200)
      begin
        bus(1'b0, OFS_CONTROL, 32'h0);
        n++;
      end
      chk({31'h0, q[BIT_DONE]}, 32'h1);
      chk({31'h0, q[BIT_BUSY]}, 32'h0);
      bus(1'b0, 4'h1, 32'h0);
      chk(q & 32'hffff, {16'h0, exp_res(code, d, lj)});
      chk(n_step - s0, SAR_CLOCKS);
      chk(gap, 2 * (dv + 1));
      if (m == 1)
      begin
        // A second start well inside the minimum period must be dropped
        pulse(1);
        bus(1'b0, OFS_CONTROL, 32'h0);
        chk({31'h0, q[BIT_BUSY]}, 32'h0);
      end
      EXT_START <= 1'b0;
      if (m < 2)
        chk({31'h0, TRACK_EN}, 32'h1);
      else if (m == 3)
        chk({31'h0, TRACK_EN}, 32'h0);
      repeat (300) @(posedge CLK_SYS);
      $display("conversion test %0d done", k);
    end
    bus(1'b1, OFS_CONTROL, 32'h0);
    @(posedge CLK_SYS);
    chk({31'h0, ANALOG_POWER}, 32'h0);
    $display("shutdown test done");
    summarize();
  end
endmodule // tb_sar_adc_conversion_control
